// ==== design/pvcc_cal_engine.sv ====
// Purpose: Calibration clock divider and calibration sequencer
// Assumes: clk is the divided reference clock; start is a one-cycle pulse
// Notes:   Divider choice is latched at start so a mid-run write cannot skew the run
`include "pvcc_defines.svh"
module pvcc_cal_engine (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       presetn,
    input  wire logic       ce,
    // Control
    input  wire logic       start,
    input  wire logic       abort,
    input  wire logic [1:0] div_sel,
    // Status
    output logic            busy,
    output logic            done,
    output logic            cal_tick
);

    // Divide ratio for a divider selection: 2, 4, 8 or 16
    function automatic logic [4:0] divisor(input logic [1:0] sel);
        divisor = `PVCC_DIV_BASE << sel;
    endfunction : divisor

    pvcc_pkg::pvcc_cal_state_t state_r, state_nxt;  // Sequencer state
    logic [3:0]                div_cnt_r, div_cnt_nxt;  // Reference cycles within one cal clock
    logic [7:0]                tick_cnt_r, tick_cnt_nxt; // Cal clocks spent
    logic [1:0]                div_lat_r, div_lat_nxt;  // Divider held for the run
    logic [4:0]                div_last;                // Divisor minus one
    logic                      tick;                    // One cal clock elapsed

    // Tick when the divider wraps
    always_comb begin
        div_last = divisor(div_lat_r) - 5'h01;
        tick     = (state_r == pvcc_pkg::PVCC_RUN) && (div_cnt_r == div_last[3:0]);
    end

    // Next state
    always_comb begin
        state_nxt    = state_r;
        div_cnt_nxt  = div_cnt_r;
        tick_cnt_nxt = tick_cnt_r;
        div_lat_nxt  = div_lat_r;
        if (abort) begin
            // Result discarded; back to idle
            state_nxt    = pvcc_pkg::PVCC_IDLE;
            div_cnt_nxt  = 4'h0;
            tick_cnt_nxt = 8'h00;
        end else begin
            case (state_r)
                pvcc_pkg::PVCC_IDLE, pvcc_pkg::PVCC_DONE: begin
                    // Only an edge pulse starts a run
                    if (start) begin
                        state_nxt    = pvcc_pkg::PVCC_RUN;
                        div_cnt_nxt  = 4'h0;
                        tick_cnt_nxt = 8'h00;
                        div_lat_nxt  = div_sel;
                    end
                end
                pvcc_pkg::PVCC_RUN: begin
                    // Count reference cycles, then cal clocks
                    div_cnt_nxt = tick ? 4'h0 : div_cnt_r + 4'h1;
                    if (tick) begin
                        tick_cnt_nxt = tick_cnt_r + 8'h01;
                        if (tick_cnt_r == `PVCC_CAL_TICKS - 8'h01) begin
                            state_nxt = pvcc_pkg::PVCC_DONE;
                        end
                    end
                end
                default: begin
                    state_nxt = pvcc_pkg::PVCC_IDLE;
                end
            endcase
        end
    end

    // State registers, frozen while ce is low
    always_ff @(posedge clk or negedge presetn) begin
        if (!presetn) begin
            state_r    <= pvcc_pkg::PVCC_IDLE;
            div_cnt_r  <= 4'h0;
            tick_cnt_r <= 8'h00;
            div_lat_r  <= `PVCC_DIV16_SEL;  // Reset divider is 16
        end else if (ce) begin
            state_r    <= state_nxt;
            div_cnt_r  <= div_cnt_nxt;
            tick_cnt_r <= tick_cnt_nxt;
            div_lat_r  <= div_lat_nxt;
        end
    end

    assign busy     = (state_r == pvcc_pkg::PVCC_RUN);
    assign done     = (state_r == pvcc_pkg::PVCC_DONE);
    assign cal_tick = tick;

    // Helper: enabled cycles since start or last tick
    logic [4:0] gap_r;
    always_ff @(posedge clk or negedge presetn) begin
        if (!presetn) begin
            gap_r <= 5'h00;
        end else if (ce) begin
            gap_r <= (start || tick) ? 5'h01 : gap_r + 5'h01;
        end
    end

    // Divide by 16 spacing of cal clocks
    a_div16_spacing: assert property (@(posedge clk) disable iff (!presetn)
        (ce && tick && div_lat_r == `PVCC_DIV16_SEL) |-> (gap_r == `PVCC_DIV16))
        else $error("Cal clock spacing is not 16 at divider 11");

    c_div16_run: cover property (@(posedge clk) disable iff (!presetn)
        (ce && tick && div_lat_r == `PVCC_DIV16_SEL));

endmodule : pvcc_cal_engine

// ==== design/pvcc_defines.svh ====
// Purpose: Named offsets, fields, reset values and counts for the oscillator calibration control block
// Assumes: Register indices are word indices; byte address is four times the index
// Notes:   Definitions only, no logic
`ifndef PVCC_DEFINES_SVH
`define PVCC_DEFINES_SVH

// Register indices (byte address = index * 4)
`define PVCC_IDX_CAL        12'h018
`define PVCC_IDX_SYNC       12'h019
`define PVCC_IDX_HOLD       12'h01d
`define PVCC_IDX_STAT       12'h1f0
`define PVCC_IDX_XFER       12'h232

// Address split
`define PVCC_AW             14
`define PVCC_IDX_HI         13
`define PVCC_IDX_LO         2

// Calibration control fields
`define PVCC_CAL_TRIG       0
`define PVCC_CAL_DIV        2:1
`define PVCC_CAL_RST        8'h06

// Counter alignment and path delay fields
`define PVCC_SYNC_MODE      7:6
`define PVCC_SYNC_REFDLY    5:3
`define PVCC_SYNC_FBDLY     2:0
`define PVCC_SYNC_RST       8'h00

// Holdover enables and transfer bit
`define PVCC_HOLD_EN        1:0
`define PVCC_HOLD_RST       8'h00
`define PVCC_XFER_BIT       0

// Alignment pin response codes
`define PVCC_MODE_ASYNC     2'h1
`define PVCC_MODE_SYNC      2'h2

// Calibration engine
`define PVCC_DIV_BASE       5'h02
`define PVCC_DIV16_SEL      2'h3
`define PVCC_DIV16          5'h10
`define PVCC_CAL_TICKS      8'h40

`endif

// ==== design/pvcc_pkg.sv ====
// Purpose: Shared types for the oscillator calibration control block
// Assumes: Constants live in pvcc_defines.svh
// Notes:   Nothing here is imported; users write pvcc_pkg::name
package pvcc_pkg;

    // APB request as presented on the bus
    typedef struct packed {
        logic [13:0] addr;   // Byte address
        logic        write;  // Direction
        logic [31:0] wdata;  // Write data
    } pvcc_apb_req_t;

    // Active alignment and delay settings
    typedef struct packed {
        logic [1:0] sync_mode;  // Alignment pin response
        logic [2:0] ref_dly;    // Reference path delay
        logic [2:0] fb_dly;     // Feedback path delay
    } pvcc_path_cfg_t;

    // Calibration sequencer states
    typedef enum logic [1:0] {
        PVCC_IDLE,
        PVCC_RUN,
        PVCC_DONE
    } pvcc_cal_state_t;

endpackage : pvcc_pkg

// ==== design/pvcc_top.sv ====
// Purpose: Oscillator calibration control with buffered registers over APB
// Assumes: pclk is the divided reference clock at 250 MHz; align_pin_n comes from a pin
// Notes:   Writes land in buffer registers; the transfer bit copies them to the active set
// Notes on behaviour
// - Divider field 11 divides reference by 16
// - Calibration starts only on active trigger rising
// - Clearing active trigger discards calibration result
// - Mode field picks alignment pin counter reset
// - Delay fields drive reference and feedback paths
`include "pvcc_defines.svh"
module pvcc_top (
    // Clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [13:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Alignment pin, active low
    input  wire logic        align_pin_n,
    // Calibration status
    output logic             cal_clk_en,
    output logic             cal_busy,
    output logic             cal_done,
    // Counter resets and path settings
    output logic             ctr_reset_level,
    output logic             ctr_reset_pulse,
    output logic [2:0]       ref_path_delay,
    output logic [2:0]       fb_path_delay,
    output logic [1:0]       holdover_en
);

    // Register index hit at an aligned byte address
    function automatic logic reg_hit(input logic [13:0] addr, input logic [11:0] idx);
        reg_hit = (addr[`PVCC_IDX_HI:`PVCC_IDX_LO] == idx) && (addr[1:0] == 2'h0);
    endfunction : reg_hit

    pvcc_pkg::pvcc_apb_req_t req;  // Request as presented
    logic        setup;            // Setup phase
    logic        access;           // Access phase
    logic        mapped;           // Address is a register
    logic        wr_en;            // Write takes effect this edge
    logic        xfer;             // Buffer to active copy this edge
    logic        start;            // Rising edge of active trigger
    logic        abort;            // Active trigger low
    logic        eng_busy;         // Engine running
    logic        eng_done;         // Engine holds a result
    logic        eng_tick;         // Cal clock pulse

    logic [7:0]  cal_buf_r,  cal_buf_nxt;   // Calibration control buffer
    logic [7:0]  cal_act_r,  cal_act_nxt;   // Calibration control active
    logic [7:0]  sync_buf_r, sync_buf_nxt;  // Alignment and delay buffer
    logic [7:0]  hold_buf_r, hold_buf_nxt;  // Holdover buffer
    logic [7:0]  hold_act_r, hold_act_nxt;  // Holdover active
    pvcc_pkg::pvcc_path_cfg_t path_r, path_nxt;  // Active alignment and delays
    logic        trig_prev_r;               // Active trigger one cycle ago
    logic [31:0] prdata_r, prdata_nxt;      // Read data captured at setup

    // Bus decode; zero wait states
    always_comb begin
        req     = '{addr: paddr, write: pwrite, wdata: pwdata};
        setup   = psel && !penable;
        access  = psel && penable;
        mapped  = reg_hit(req.addr, `PVCC_IDX_CAL) || reg_hit(req.addr, `PVCC_IDX_SYNC)
               || reg_hit(req.addr, `PVCC_IDX_HOLD) || reg_hit(req.addr, `PVCC_IDX_STAT)
               || reg_hit(req.addr, `PVCC_IDX_XFER);
        wr_en   = ce && access && req.write && mapped;
        xfer    = wr_en && reg_hit(req.addr, `PVCC_IDX_XFER) && req.wdata[`PVCC_XFER_BIT];
    end

    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    // Register next values: buffer writes, transfer to active, read capture
    always_comb begin
        cal_buf_nxt  = cal_buf_r;
        sync_buf_nxt = sync_buf_r;
        hold_buf_nxt = hold_buf_r;
        cal_act_nxt  = cal_act_r;
        hold_act_nxt = hold_act_r;
        path_nxt     = path_r;
        prdata_nxt   = prdata_r;
        if (wr_en && reg_hit(req.addr, `PVCC_IDX_CAL)) begin
            cal_buf_nxt = req.wdata[7:0];
        end
        if (wr_en && reg_hit(req.addr, `PVCC_IDX_SYNC)) begin
            sync_buf_nxt = req.wdata[7:0];
        end
        if (wr_en && reg_hit(req.addr, `PVCC_IDX_HOLD)) begin
            hold_buf_nxt = req.wdata[7:0];
        end
        if (xfer) begin
            // Active set only changes here, so a trigger edge needs a transfer
            cal_act_nxt        = cal_buf_r;
            hold_act_nxt       = hold_buf_r;
            path_nxt.sync_mode = sync_buf_r[`PVCC_SYNC_MODE];
            path_nxt.ref_dly   = sync_buf_r[`PVCC_SYNC_REFDLY];
            path_nxt.fb_dly    = sync_buf_r[`PVCC_SYNC_FBDLY];
        end
        if (ce && setup) begin
            // Read data sampled in setup, held through access
            prdata_nxt = 32'h0000_0000;
            if (reg_hit(req.addr, `PVCC_IDX_CAL)) begin
                prdata_nxt[7:0] = cal_buf_r;
            end else if (reg_hit(req.addr, `PVCC_IDX_SYNC)) begin
                prdata_nxt[7:0] = sync_buf_r;
            end else if (reg_hit(req.addr, `PVCC_IDX_HOLD)) begin
                prdata_nxt[7:0] = hold_buf_r;
            end else if (reg_hit(req.addr, `PVCC_IDX_STAT)) begin
                // Busy, done, active trigger, holdover active during a run
                prdata_nxt[3:0] = {eng_busy && (hold_act_r[`PVCC_HOLD_EN] != 2'h0),
                                   cal_act_r[`PVCC_CAL_TRIG], eng_done, eng_busy};
            end
        end
    end

    // Register group, frozen while ce is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_buf_r   <= `PVCC_CAL_RST;
            cal_act_r   <= `PVCC_CAL_RST;
            sync_buf_r  <= `PVCC_SYNC_RST;
            hold_buf_r  <= `PVCC_HOLD_RST;
            hold_act_r  <= `PVCC_HOLD_RST;
            path_r      <= '0;
            prdata_r    <= 32'h0000_0000;
            trig_prev_r <= 1'b0;
        end else if (ce) begin
            cal_buf_r   <= cal_buf_nxt;
            cal_act_r   <= cal_act_nxt;
            sync_buf_r  <= sync_buf_nxt;
            hold_buf_r  <= hold_buf_nxt;
            hold_act_r  <= hold_act_nxt;
            path_r      <= path_nxt;
            prdata_r    <= prdata_nxt;
            trig_prev_r <= cal_act_r[`PVCC_CAL_TRIG];
        end
    end

    // A held one never restarts; only the 0 to 1 step does
    assign start = ce && cal_act_r[`PVCC_CAL_TRIG] && !trig_prev_r;
    assign abort = !cal_act_r[`PVCC_CAL_TRIG];

    // Calibration divider and sequencer
    pvcc_cal_engine u_engine (
        .clk        (pclk),
        .presetn    (presetn),
        .ce         (ce),
        .start      (start),
        .abort      (abort),
        .div_sel    (cal_act_r[`PVCC_CAL_DIV]),
        .busy       (eng_busy),
        .done       (eng_done),
        .cal_tick   (eng_tick)
    );

    // Alignment pin synchroniser and counter reset decode
    logic sync_s1_r, sync_s2_r, sync_s3_r;  // Two-flop sync plus edge history
    logic lvl_nxt, pulse_nxt;               // Next counter reset outputs
    logic lvl_r, pulse_r;                   // Registered counter resets

    always_comb begin
        // Pin asserted is low; only the second stage and later are read
        lvl_nxt   = (path_r.sync_mode == `PVCC_MODE_ASYNC) && !sync_s2_r;
        pulse_nxt = (path_r.sync_mode == `PVCC_MODE_SYNC) && !sync_s2_r && sync_s3_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_s1_r <= 1'b1;
            sync_s2_r <= 1'b1;
            sync_s3_r <= 1'b1;
            lvl_r     <= 1'b0;
            pulse_r   <= 1'b0;
        end else if (ce) begin
            sync_s1_r <= align_pin_n;
            sync_s2_r <= sync_s1_r;
            sync_s3_r <= sync_s2_r;
            lvl_r     <= lvl_nxt;
            pulse_r   <= pulse_nxt;
        end
    end

    // Outputs
    assign prdata          = prdata_r;
    assign cal_clk_en      = eng_tick;
    assign cal_busy        = eng_busy;
    assign cal_done        = eng_done;
    assign ctr_reset_level = lvl_r;
    assign ctr_reset_pulse = pulse_r && ce;
    assign ref_path_delay  = path_r.ref_dly;
    assign fb_path_delay   = path_r.fb_dly;
    assign holdover_en     = hold_act_r[`PVCC_HOLD_EN];

    // Rising active trigger starts the engine next cycle
    a_trig_edge_start: assert property (@(posedge pclk) disable iff (!presetn)
        (start && !abort) |=> (cal_busy || !ce))
        else $error("Trigger rising edge did not start calibration");

    // Trigger held high after a finished run does not restart it
    a_level_no_start: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && cal_done && cal_act_r[`PVCC_CAL_TRIG] && trig_prev_r) |=> (!cal_busy || $past(xfer)))
        else $error("Held trigger restarted calibration");

    // Cleared active trigger discards result within one enabled cycle
    a_clear_discard: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && abort) |=> (!cal_done && !cal_busy))
        else $error("Calibration result kept after trigger cleared");

    // Outside asynchronous mode the level counter reset stays low
    a_sync_ignore: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && path_r.sync_mode != `PVCC_MODE_ASYNC && $past(path_r.sync_mode) != `PVCC_MODE_ASYNC)
        |-> !ctr_reset_level)
        else $error("Counter level reset outside asynchronous mode");

    // Synchronous mode pulse lasts one cycle only
    a_sync_pulse_one: assert property (@(posedge pclk) disable iff (!presetn)
        (ctr_reset_pulse && ce) |=> !ctr_reset_pulse)
        else $error("Synchronous counter reset wider than one cycle");

    // Transfer moves buffered delays to the path outputs
    a_delay_xfer: assert property (@(posedge pclk) disable iff (!presetn)
        xfer |=> (ref_path_delay == $past(sync_buf_r[`PVCC_SYNC_REFDLY])
              && fb_path_delay == $past(sync_buf_r[`PVCC_SYNC_FBDLY])))
        else $error("Path delays not taken from buffer on transfer");

    c_cal_complete: cover property (@(posedge pclk) disable iff (!presetn) $rose(cal_done));
    c_cal_abort: cover property (@(posedge pclk) disable iff (!presetn) cal_busy ##1 !cal_busy && abort);
    c_sync_pulse: cover property (@(posedge pclk) disable iff (!presetn) ctr_reset_pulse);
    c_async_hold: cover property (@(posedge pclk) disable iff (!presetn) ctr_reset_level [*3]);

endmodule : pvcc_top

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the oscillator calibration control block
// Assumes: Zero-wait APB slave; register index times four is the byte address
// Notes:   ce drops only in the freeze check; every scenario is its own task and judges itself
`include "pvcc_defines.svh"
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    // Bus and pin stimulus
    logic        pclk        = 1'b0;
    logic        presetn     = 1'b0;
    logic        ce          = 1'b1;   // High except in the freeze check
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [13:0] paddr       = 14'h0000;
    logic [31:0] pwdata      = 32'h00000000;
    logic        align_pin_n = 1'b1;   // Pin idle high
    // Observed outputs
    logic [31:0] prdata;
    logic        pready, pslverr, cal_clk_en, cal_busy, cal_done;
    logic        ctr_reset_level, ctr_reset_pulse;
    logic [2:0]  ref_path_delay, fb_path_delay;
    logic [1:0]  holdover_en;
    // Bookkeeping
    int          num_errors = 0;
    int          cmp_count  = 0;
    int          cyc        = 0;

    // Byte addresses built from word indices
    localparam logic [13:0] A_CAL  = {`PVCC_IDX_CAL, 2'b00};
    localparam logic [13:0] A_SYNC = {`PVCC_IDX_SYNC, 2'b00};
    localparam logic [13:0] A_HOLD = {`PVCC_IDX_HOLD, 2'b00};
    localparam logic [13:0] A_XFER = {`PVCC_IDX_XFER, 2'b00};
    localparam logic [13:0] A_STAT = {`PVCC_IDX_STAT, 2'b00};

    pvcc_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .align_pin_n(align_pin_n), .cal_clk_en(cal_clk_en),
        .cal_busy(cal_busy), .cal_done(cal_done), .ctr_reset_level(ctr_reset_level),
        .ctr_reset_pulse(ctr_reset_pulse), .ref_path_delay(ref_path_delay),
        .fb_path_delay(fb_path_delay), .holdover_en(holdover_en));

    // Free-running bus clock, 4 ns period
    always #2 pclk = ~pclk;

    // Hang guard; longest legal run is a few thousand cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            $display("CHECK FAILED at %0t: run timed out", $time);
            summarize();
        end
    end

    // Counts then verdict, single exit point
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize

    // Count one comparison, report a miss at once
    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask : check

    // One APB transfer; entered just after a rising edge, idle cycle after
    task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait ends once pready is high; the bench timeout catches a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Write helper
    task automatic wr(input logic [13:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, {24'h000000, d}, rd, err);
    endtask : wr

    // Read and compare helper
    task automatic rd_chk(input logic [13:0] a, input logic [31:0] exp, input logic exp_err, input string msg);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h00000000, rd, err);
        check(rd === exp && err === exp_err, msg);
    endtask : rd_chk

    // Reset values and an unmapped read
    task automatic t_reset();
        rd_chk(A_CAL, {24'h0, `PVCC_CAL_RST}, 1'b0, "cal control reset value");
        rd_chk(A_SYNC, 32'h00000000, 1'b0, "sync/delay reset value");
        check(ref_path_delay === 3'h0 && fb_path_delay === 3'h0, "delays not zero");
        rd_chk(14'h0ffc, 32'h00000000, 1'b1, "unmapped read not refused");
        $display("t_reset done");
    endtask : t_reset

    // Delay fields stay buffered until transfer
    task automatic t_delay();
        // Writes with ce low must leave every register untouched
        ce <= 1'b0;
        wr(A_SYNC, 8'h3f);
        wr(A_XFER, 8'h01);
        ce <= 1'b1;
        check(ref_path_delay === 3'h0 && fb_path_delay === 3'h0, "delay changed while frozen");
        rd_chk(A_SYNC, 32'h00000000, 1'b0, "buffer written while frozen");
        wr(A_SYNC, 8'h2b);
        check(ref_path_delay === 3'h0, "delay moved before transfer");
        wr(A_XFER, 8'h01);
        check(ref_path_delay === 3'h5 && fb_path_delay === 3'h3, "path delay fields");
        rd_chk(A_SYNC, 32'h0000002b, 1'b0, "sync readback");
        wr(A_HOLD, 8'h03);
        check(holdover_en === 2'h0, "holdover moved before transfer");
        wr(A_XFER, 8'h01);
        check(holdover_en === 2'h3, "holdover active value");
        wr(A_HOLD, 8'h00);
        wr(A_SYNC, 8'h00);
        wr(A_XFER, 8'h01);
        $display("t_delay done");
    endtask : t_delay

    // Every alignment mode with a held pin assertion
    task automatic t_align();
        int lvl, pls;
        for (int m = 0; m < 4; m++) begin
            wr(A_SYNC, {m[1:0], 6'h00});
            wr(A_XFER, 8'h01);
            lvl = 0;
            pls = 0;
            align_pin_n <= 1'b0;
            repeat (10) begin
                @(posedge pclk);
                lvl += (ctr_reset_level === 1'b1);
                pls += (ctr_reset_pulse === 1'b1);
            end
            align_pin_n <= 1'b1;
            repeat (6) @(posedge pclk);
            check(ctr_reset_level === 1'b0, "level reset stuck");
            check(lvl >= ((m == 1) ? 5 : 0) && lvl <= ((m == 1) ? 10 : 0), "level reset count");
            check(pls == ((m == 2) ? 1 : 0), "pulse reset count");
        end
        wr(A_SYNC, 8'h00);
        wr(A_XFER, 8'h01);
        $display("t_align done");
    endtask : t_align

    // Full calibration sequence at one divider setting
    task automatic run_cal(input logic [1:0] div, input int divisor);
        int n, ticks;
        wr(A_HOLD, 8'h00);
        wr(A_CAL, {5'h00, div, 1'b0});
        wr(A_XFER, 8'h01);
        check(cal_busy === 1'b0, "busy without trigger edge");
        wr(A_CAL, {5'h00, div, 1'b1});
        wr(A_XFER, 8'h01);
        n = 0;
        ticks = 0;
        while (cal_busy !== 1'b1 && cal_done !== 1'b1 && n < 10) begin
            @(posedge pclk);
            n++;
        end
        check(cal_busy === 1'b1, "calibration did not start");
        check(holdover_en === 2'h0, "holdover enabled during calibration");
        n = 0;
        while (cal_done !== 1'b1 && n < 3000) begin
            @(posedge pclk);
            ticks += (cal_clk_en === 1'b1);
            n++;
        end
        check(ticks == 64, "calibration clock tick count");
        check(n >= 64 * divisor - 4 && n <= 64 * divisor + 4, "calibration length vs divider");
        wr(A_XFER, 8'h01);
        repeat (4) @(posedge pclk);
        check(cal_busy === 1'b0 && cal_done === 1'b1, "restart on held trigger");
        rd_chk(A_STAT, 32'h00000006, 1'b0, "status after finished run");
        wr(A_CAL, {5'h00, div, 1'b0});
        wr(A_XFER, 8'h01);
        repeat (2) @(posedge pclk);
        check(cal_done === 1'b0, "result kept after trigger clear");
    endtask : run_cal

    // Default divider first, then the other three
    task automatic t_cal();
        run_cal(2'h3, 16);
        run_cal(2'h0, 2);
        run_cal(2'h1, 4);
        run_cal(2'h2, 8);
        // Clearing the trigger mid-run drops the run
        wr(A_CAL, 8'h07);
        wr(A_XFER, 8'h01);
        repeat (20) @(posedge pclk);
        check(cal_busy === 1'b1, "abort run did not start");
        wr(A_CAL, 8'h06);
        wr(A_XFER, 8'h01);
        repeat (2) @(posedge pclk);
        check(cal_busy === 1'b0 && cal_done === 1'b0, "run kept after trigger clear");
        $display("t_cal done");
    endtask : t_cal

    // Main sequence; reference clock runs before any calibration
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_delay();
        t_align();
        t_cal();
        summarize();
    end
endmodule : testbench
